//--- logic/tols_pkg.sv
// Shared constants and types for the three-operand logical shift
package tols_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int DATA_W = 32;
  localparam int COUNT_W = 7;
  localparam int REG_W = 5;
  localparam int FIELD_W = 8;
  localparam int MODE_W = 2;
  localparam int AUX_W = 3;
  localparam int OPC_W = 9;
  localparam int DISP_SEL_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction word layout
  localparam logic [OPC_W-1:0] OPCODE_PREFIX = 9'h048;
  localparam int OPC_LO = 23;
  localparam int MODE_LO = 21;
  localparam int DST_LO = 16;
  localparam int SRC_LO = 8;
  localparam int CNT_LO = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Operand mode bits and destination limits
  localparam int SRC_MEM_BIT = 0;
  localparam int CNT_MEM_BIT = 1;
  localparam logic [REG_W-1:0] LOW_REG_COUNT = 5'h08;
  localparam logic [REG_W-1:0] DST_LAST = 5'h1b;

  ////////////////////////////////////////////////////////////////////////////
  // Indirect displacement select codes, top bits of the operand field
  localparam logic [DISP_SEL_W-1:0] DISP_SEL_ONE = 2'h0;
  localparam logic [DISP_SEL_W-1:0] DISP_SEL_INDEX_ZERO = 2'h1;
  localparam logic [DISP_SEL_W-1:0] DISP_SEL_INDEX_ONE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {DISP_ZERO, DISP_ONE, DISP_INDEX_ZERO, DISP_INDEX_ONE} tols_disp_type;

  typedef struct packed {
    logic latchedUnderflowFlag;
    logic latchedOverflowFlag;
    logic underflowFlag;
    logic n;
    logic z;
    logic v;
    logic c;
  } tols_flags_type;

  typedef struct packed {
    logic isMemory;
    logic [REG_W-1:0] regIndex;
    tols_disp_type disp;
    logic [AUX_W-1:0] auxIndex;
  } tols_operand_type;

  typedef struct packed {
    logic write;
    logic [REG_W-1:0] dst;
    logic [DATA_W-1:0] data;
  } tols_result_type;

  typedef struct packed {
    tols_result_type result;
    logic flagsWrite;
    tols_flags_type flags;
    tols_operand_type srcOp;
    tols_operand_type cntOp;
    logic badInstr;
  } tols_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Destination in the low result registers
  function automatic logic isLowReg(input logic [REG_W-1:0] r);
    return r < LOW_REG_COUNT;
  endfunction

endpackage

//--- logic/tols_operand_select.sv
// Operand field decode: register or indirect memory operand
`timescale 1ns/10ps
module tols_operand_select
  import tols_pkg::*;
#(
  parameter int MEM_BIT = SRC_MEM_BIT
)
(
  // Mode and operand field
  input wire logic [MODE_W-1:0] mode,
  input wire logic [FIELD_W-1:0] field,
  // Decoded operand
  output tols_operand_type operand
);

  always_comb begin
    operand.isMemory = mode[MEM_BIT];
    operand.regIndex = field[REG_W-1:0];
    operand.auxIndex = field[AUX_W-1:0];
    unique case (field[FIELD_W-1 -: DISP_SEL_W])
      DISP_SEL_ONE: operand.disp = DISP_ONE;
      DISP_SEL_INDEX_ZERO: operand.disp = DISP_INDEX_ZERO;
      DISP_SEL_INDEX_ONE: operand.disp = DISP_INDEX_ONE;
      default: operand.disp = DISP_ZERO;
    endcase
  end

endmodule

//--- logic/tols_shift_core.sv
// Logical shift by a signed seven-bit count with carry out
`timescale 1ns/10ps
module tols_shift_core
  import tols_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int CW = COUNT_W
)
(
  // Operands
  input wire logic [WIDTH-1:0] source,
  input wire logic [CW-1:0] count,
  // Shifted value and last bit out
  output logic [WIDTH-1:0] result,
  output logic carry
);

  logic [2*WIDTH-1:0] wide;
  logic [CW-1:0] magnitude;

  always_comb begin
    magnitude = '0;
    wide = '0;
    if (count[CW-1]) begin
      // Right shift, zeros enter at the top
      magnitude = CW'(-count);
      wide = {source, {WIDTH{1'b0}}} >> magnitude;
      result = wide[2*WIDTH-1:WIDTH];
      carry = wide[WIDTH-1];
    end else begin
      // Left shift, zero count leaves source and clears carry
      wide = {{WIDTH{1'b0}}, source} << count;
      result = wide[WIDTH-1:0];
      carry = wide[WIDTH];
    end
  end

endmodule

//--- logic/tols_top.sv
// Execute-stage datapath of the three-operand logical shift
//
// Overview of operation
// - Shift amount is the low seven count bits, read as signed.
// - Positive count: source copy shifted left into destination, zeros in.
// - Left shift: bits leave the top through carry, zeros enter the bottom.
// - Negative count: source shifted right by the magnitude, zeros fill the top.
// - Right shift: bits leave the bottom through carry.
// - Zero count: no shift, carry cleared.
// - Source and result are unsigned; right shift never copies the sign.
// - Flags change only for low destinations; latched flags never change.
// - Flag update clears underflow and overflow, sets negative and zero from the result.
// - Carry takes the last bit out, zero for a zero count.
// - Saturation mode has no influence on result or flags.
// - Mode codes 00 and 10 take a register source, 01 and 11 memory.
// - Mode codes 00 and 01 take a register count, 10 and 11 memory.
`timescale 1ns/10ps
module tols_top
  import tols_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Issue from decoder
  input wire logic issue,
  input wire logic [DATA_W-1:0] instr,
  // Operand values
  input wire logic [DATA_W-1:0] srcRegData,
  input wire logic [DATA_W-1:0] srcMemData,
  input wire logic [DATA_W-1:0] countRegData,
  input wire logic [DATA_W-1:0] countMemData,
  // Current status
  input wire tols_flags_type statusIn,
  // Result write
  output tols_result_type result,
  // Status write
  output logic flagsWrite,
  output tols_flags_type flagsOut,
  // Operand paths taken
  output tols_operand_type srcPath,
  output tols_operand_type countPath,
  // Rejected instruction
  output logic badInstr
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] resetSync;
  logic rstSyncB;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetSync <= 2'h0;
    end else begin
      resetSync <= {resetSync[0], 1'b1};
    end
  end

  assign rstSyncB = resetSync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields

  logic [OPC_W-1:0] opcode;
  logic [MODE_W-1:0] mode;
  logic [REG_W-1:0] dstIndex;
  logic [FIELD_W-1:0] srcField;
  logic [FIELD_W-1:0] cntField;
  logic instrOk;

  assign opcode = instr[OPC_LO +: OPC_W];
  assign mode = instr[MODE_LO +: MODE_W];
  assign dstIndex = instr[DST_LO +: REG_W];
  assign srcField = instr[SRC_LO +: FIELD_W];
  assign cntField = instr[CNT_LO +: FIELD_W];
  assign instrOk = (opcode == OPCODE_PREFIX) && (dstIndex <= DST_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection

  tols_operand_type srcOperand;
  tols_operand_type cntOperand;
  logic [DATA_W-1:0] srcData;
  logic [DATA_W-1:0] countData;

  tols_operand_select #(
    .MEM_BIT(SRC_MEM_BIT)
  ) srcSelect (
    .mode(mode),
    .field(srcField),
    .operand(srcOperand)
  );

  tols_operand_select #(
    .MEM_BIT(CNT_MEM_BIT)
  ) cntSelect (
    .mode(mode),
    .field(cntField),
    .operand(cntOperand)
  );

  assign srcData = srcOperand.isMemory ? srcMemData : srcRegData;
  assign countData = cntOperand.isMemory ? countMemData : countRegData;

  ////////////////////////////////////////////////////////////////////////////
  // Shifter

  logic [DATA_W-1:0] shiftData;
  logic shiftCarry;

  tols_shift_core #(
    .WIDTH(DATA_W),
    .CW(COUNT_W)
  ) shifter (
    .source(srcData),
    .count(countData[COUNT_W-1:0]),
    .result(shiftData),
    .carry(shiftCarry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  tols_state_type state;
  tols_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.result.write = 1'b0;
    next_state.flagsWrite = 1'b0;
    next_state.badInstr = 1'b0;
    if (issue) begin
      next_state.srcOp = srcOperand;
      next_state.cntOp = cntOperand;
      if (!instrOk) begin
        next_state.badInstr = 1'b1;
      end else begin
        // Written at the end of the single execute cycle
        next_state.result.write = 1'b1;
        next_state.result.dst = dstIndex;
        next_state.result.data = shiftData;
        // No saturation input: flags are never clamped
        next_state.flags = statusIn;
        if (isLowReg(dstIndex)) begin
          next_state.flagsWrite = 1'b1;
          next_state.flags.underflowFlag = 1'b0;
          next_state.flags.v = 1'b0;
          next_state.flags.n = shiftData[DATA_W-1];
          next_state.flags.z = (shiftData == '0);
          next_state.flags.c = shiftCarry;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign result = state.result;
  assign flagsWrite = state.flagsWrite;
  assign flagsOut = state.flags;
  assign srcPath = state.srcOp;
  assign countPath = state.cntOp;
  assign badInstr = state.badInstr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic chkLegal;
  logic chkLow;
  logic signed [COUNT_W-1:0] chkCount;
  logic [COUNT_W-1:0] chkMag;
  logic chkLeftOut;
  logic chkRightOut;

  assign chkLegal = issue && instrOk;
  assign chkLow = isLowReg(dstIndex);
  assign chkCount = countData[COUNT_W-1:0];
  assign chkMag = COUNT_W'(-chkCount);

  always_comb begin
    chkLeftOut = 1'b0;
    chkRightOut = 1'b0;
    if (chkCount > 0 && chkCount <= DATA_W) begin
      chkLeftOut = srcData[DATA_W - chkCount];
    end
    if (chkCount < 0 && chkMag <= DATA_W) begin
      chkRightOut = srcData[chkMag - 1];
    end
  end

  left_result_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkCount > 0 |=>
        result.data == ($past(srcData) << $past(chkCount)))
    else $error("left shift result wrong");

  right_result_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkCount < 0 |=>
        result.data == ($past(srcData) >> $past(chkMag)))
    else $error("right shift result wrong");

  low_count_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkCount == 0 |=> result.data == $past(srcData))
    else $error("upper count bits changed the shift");

  left_carry_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkLow && chkCount > 0 |=> flagsOut.c == $past(chkLeftOut))
    else $error("left carry is not the last bit out");

  right_carry_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkLow && chkCount < 0 |=> flagsOut.c == $past(chkRightOut))
    else $error("right carry is not the last bit out");

  zero_carry_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkLow && chkCount == 0 |=> flagsWrite && !flagsOut.c)
    else $error("zero count did not clear carry");

  no_sign_fill_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkCount < 0 |=> !result.data[DATA_W-1])
    else $error("right shift copied the sign");

  high_dst_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && !chkLow |=> result.write && !flagsWrite)
    else $error("flags written for a high destination");

  latched_keep_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      flagsWrite |-> flagsOut.latchedUnderflowFlag == $past(statusIn.latchedUnderflowFlag)
        && flagsOut.latchedOverflowFlag == $past(statusIn.latchedOverflowFlag))
    else $error("latched flags were changed");

  flag_values_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      flagsWrite |-> !flagsOut.underflowFlag && !flagsOut.v
        && flagsOut.n == result.data[DATA_W-1]
        && flagsOut.z == (result.data == '0))
    else $error("flag values wrong");

  src_select_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      issue |=> srcPath.isMemory == $past(mode[SRC_MEM_BIT]))
    else $error("source path wrong");

  count_select_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      issue |=> countPath.isMemory == $past(mode[CNT_MEM_BIT]))
    else $error("count path wrong");

  bad_word_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      issue && opcode != OPCODE_PREFIX |=> badInstr && !result.write)
    else $error("foreign word was executed");

  one_cycle_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal ##1 !issue |-> result.write && result.dst == $past(dstIndex)
        ##1 !result.write && !flagsWrite)
    else $error("result not written in one cycle");

  high_dst_flags_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && !chkLow |=> flagsOut == $past(statusIn))
    else $error("flags changed for a high destination");

  flags_hold_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      !issue |=> $stable(flagsOut) && $stable(result.data))
    else $error("flags or result moved without an issue");

  long_dst_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      issue && dstIndex > DST_LAST |=> badInstr && !result.write && !flagsWrite)
    else $error("destination above 27 was executed");

  src_port_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      chkLegal && chkCount == 0 |=> result.data == ($past(mode[SRC_MEM_BIT])
        ? $past(srcMemData) : $past(srcRegData)))
    else $error("source taken from the wrong port");

  field_index_a:
    assert property (@(posedge clk) disable iff (!rstSyncB)
      issue |=> srcPath.regIndex == $past(srcField[REG_W-1:0])
        && countPath.auxIndex == $past(cntField[AUX_W-1:0]))
    else $error("operand field indexes wrong");

endmodule

//--- dv/tols_operand_model.sv
// Operand supplier model: register file and memory ports of the core
`timescale 1ns/10ps
module tols_operand_model
  import tols_pkg::*;
(
  // Instruction on offer
  input wire logic [DATA_W-1:0] instr,
  // Wanted operand values
  input wire logic [DATA_W-1:0] srcVal,
  input wire logic [DATA_W-1:0] cntVal,
  // Operand ports
  output logic [DATA_W-1:0] srcRegData,
  output logic [DATA_W-1:0] srcMemData,
  output logic [DATA_W-1:0] countRegData,
  output logic [DATA_W-1:0] countMemData
);
  logic [MODE_W-1:0] mode;

  assign mode = instr[MODE_LO +: MODE_W];
  // Port not selected by the mode carries the inverse value
  assign srcRegData = mode[SRC_MEM_BIT] ? ~srcVal : srcVal;
  assign srcMemData = mode[SRC_MEM_BIT] ? srcVal : ~srcVal;
  assign countRegData = mode[CNT_MEM_BIT] ? ~cntVal : cntVal;
  assign countMemData = mode[CNT_MEM_BIT] ? cntVal : ~cntVal;
endmodule

//--- dv/tb.sv
// Self-checking testbench of the three-operand logical shift
`timescale 1ns/10ps
module tb;
  import tols_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic issue = 1'b0;
  logic [DATA_W-1:0] instr = '0;
  logic [DATA_W-1:0] srcVal = '0;
  logic [DATA_W-1:0] cntVal = '0;
  logic [DATA_W-1:0] srcRegData, srcMemData, countRegData, countMemData;
  tols_flags_type statusIn = '0;
  tols_result_type result;
  logic flagsWrite, badInstr;
  tols_flags_type flagsOut;
  tols_operand_type srcPath, countPath;
  int fails = 0;
  int tests_run = 0;

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  tols_operand_model model_u (.instr(instr), .srcVal(srcVal), .cntVal(cntVal),
    .srcRegData(srcRegData), .srcMemData(srcMemData),
    .countRegData(countRegData), .countMemData(countMemData));

  tols_top dut_u (.clk(clk), .rst_b(rst_b), .issue(issue), .instr(instr),
    .srcRegData(srcRegData), .srcMemData(srcMemData),
    .countRegData(countRegData), .countMemData(countMemData),
    .statusIn(statusIn), .result(result), .flagsWrite(flagsWrite),
    .flagsOut(flagsOut), .srcPath(srcPath), .countPath(countPath),
    .badInstr(badInstr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input bit ok, input string msg);
    tests_run++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic runShift(input logic [1:0] md, input logic [4:0] dst,
                          input logic [31:0] sv, input logic [31:0] cv,
                          input tols_flags_type st);
    logic signed [6:0] k;
    int n;
    logic [31:0] d;
    logic c;
    tols_flags_type ef;
    k = cv[6:0];
    d = sv;
    c = 1'b0;
    if (k > 0) begin
      n = k;
      d = (n >= 32) ? 32'h0 : sv << n;
      c = (n <= 32) ? sv[32-n] : 1'b0;
    end else if (k < 0) begin
      n = -k;
      d = (n >= 32) ? 32'h0 : sv >> n;
      c = (n <= 32) ? sv[n-1] : 1'b0;
    end
    ef = st;
    ef.underflowFlag = 1'b0;
    ef.v = 1'b0;
    ef.n = d[31];
    ef.z = (d == 0);
    ef.c = c;
    if (dst >= 5'h08) begin
      ef = st;
    end
    instr = {OPCODE_PREFIX, md, dst, 8'h03, 8'h05};
    srcVal = sv;
    cntVal = cv;
    statusIn = st;
    issue = 1'b1;
    @(negedge clk);
    issue = 1'b0;
    check(result.write === 1'b1 && badInstr === 1'b0, "no write");
    check(result.dst === dst, "dst");
    check(result.data === d, "data");
    check(flagsWrite === (dst < 5'h08), "flag write");
    check(flagsOut === ef, "flags");
    check(srcPath.isMemory === md[0] && srcPath.regIndex === 5'h03, "src path");
    check(countPath.isMemory === md[1] && countPath.regIndex === 5'h05, "count path");
    @(negedge clk);
    check(result.write === 1'b0 && flagsWrite === 1'b0, "pulse held");
  endtask

  task automatic runBad(input logic [8:0] pfx, input logic [4:0] dst);
    instr = {pfx, 2'h0, dst, 8'h01, 8'h02};
    issue = 1'b1;
    @(negedge clk);
    issue = 1'b0;
    check(badInstr === 1'b1 && result.write === 1'b0, "refusal");
    check(flagsWrite === 1'b0, "refused flags");
    @(negedge clk);
    check(badInstr === 1'b0, "refusal pulse");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic scen_left();
    runShift(2'h0, 5'h02, 32'h000002ac, 32'h00000018, '0);
  endtask

  task automatic scen_right();
    runShift(2'h1, 5'h03, 32'h12c00000, 32'hfffffff4, '0);
  endtask

  task automatic scen_zero();
    runShift(2'h2, 5'h04, 32'h80000001, 32'h00000000, 7'h01);
  endtask

  task automatic scen_unsigned();
    runShift(2'h3, 5'h05, 32'h80000001, 32'h0000007f, '0);
  endtask

  task automatic scen_lowbits();
    runShift(2'h0, 5'h06, 32'h80000000, 32'hffffff81, '0);
    runShift(2'h0, 5'h06, 32'h00000001, 32'h12345680, '0);
  endtask

  task automatic scen_edges();
    logic [31:0] counts [6] = '{32'h20, 32'h60, 32'h40, 32'h1f, 32'h61, 32'h21};
    foreach (counts[i]) begin
      runShift(2'h0, 5'h01, 32'ha5a5a5a5, counts[i], '0);
    end
  endtask

  task automatic scen_flags();
    runShift(2'h0, 5'h09, 32'h00000003, 32'h00000001, 7'h7f);
    runShift(2'h1, 5'h1b, 32'h00000003, 32'h00000001, 7'h00);
    runShift(2'h0, 5'h07, 32'h00000003, 32'h0000007e, 7'h7f);
  endtask

  task automatic scen_modes();
    for (int m = 0; m < 4; m++) begin
      runShift(m[1:0], 5'h00, 32'h0f0f0f0f, 32'h00000004, '0);
    end
  endtask

  task automatic scen_disp();
    tols_disp_type want [4] = '{DISP_ONE, DISP_INDEX_ZERO, DISP_INDEX_ONE, DISP_ZERO};
    for (int i = 0; i < 4; i++) begin
      instr = {OPCODE_PREFIX, 2'h3, 5'h0a, i[1:0], 6'h15, ~i[1:0], 6'h2e};
      issue = 1'b1;
      @(negedge clk);
      issue = 1'b0;
      check(srcPath.disp === want[i] && srcPath.auxIndex === 3'h5, "src disp");
      check(countPath.disp === want[3-i] && countPath.auxIndex === 3'h6, "cnt disp");
      @(negedge clk);
    end
  endtask

  task automatic scen_refused();
    runBad(9'h049, 5'h01);
    runBad(OPCODE_PREFIX, 5'h1c);
    runBad(OPCODE_PREFIX, 5'h1f);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(3000 * 100);
    fails++;
    summarize();
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    scen_left();
    scen_right();
    scen_zero();
    scen_unsigned();
    scen_lowbits();
    scen_edges();
    scen_flags();
    scen_modes();
    scen_disp();
    scen_refused();
    summarize();
  end
endmodule
